//--- fims_pkg.sv
// Purpose: shared constants for the fault interrupt mask and status block
// Assumes: 20 MHz core clock, 8-bit control-port registers
// Notes:   offsets and field positions are the register map of the device
package fims_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [7:0]  FAULT_MASK_ADDR = 8'h14;
    localparam logic [7:0]  AUDIO_STAT_ADDR = 8'h15;
    localparam logic [7:0]  MON_STAT_ADDR   = 8'h16;
    localparam logic [7:0]  FAULT_MASK_RST  = 8'hff;
    localparam logic [7:0]  DATA_ZERO       = 8'h00;
    // audio status field positions
    localparam int          AUD_W           = 5;
    localparam int          AUD_SYNC_BIT    = 4;
    localparam int          AUD_MCLK_BIT    = 3;
    localparam int          AUD_SHORT_BIT   = 2;
    localparam int          AUD_WARN_BIT    = 1;
    localparam int          AUD_ERR_BIT     = 0;
    // monitor status field positions
    localparam int          MON_W           = 3;
    localparam int          MON_LSB         = 5;
    localparam int          MON_VOV_BIT     = 7;
    localparam int          MON_IOV_BIT     = 6;
    localparam int          MON_POV_BIT     = 5;
    localparam int          MON_PDN_BIT     = 0;
    localparam logic        PWR_DONE_RST    = 1'b1;
    // clock watchdog timing
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          MCLK_MIN_HZ     = 1_250_000;
    localparam int          WD_W            = 5;
    localparam logic [4:0]  WD_MAX_CYC      = 5'(CLK_HZ / MCLK_MIN_HZ);
    localparam logic [4:0]  WD_ONE          = 5'h01;
    localparam logic [4:0]  WD_ZERO         = 5'h00;
    // current monitor scale code that drives the path into clipping
    localparam int          SCALE_W         = 2;
    localparam logic [1:0]  SCALE_OVF_CODE  = 2'h3;
    localparam int          PIN_N           = 9;

    typedef enum logic [0:0] {
        FIMS_REL_IDLE  = 1'b0,
        FIMS_REL_ARMED = 1'b1
    } fims_rel_type;
endpackage : fims_pkg

//--- fims_stat_if.sv
// Purpose: carries sticky status set, clear and state between modules
// Assumes: one clock domain
// Notes:   W sets the number of sticky bits
`timescale 1ns/100ps
interface fims_stat_if #(parameter int W = 1);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] stat;
    modport owner (input set, input clr, output stat);
    modport user  (output set, output clr, input stat);
endinterface : fims_stat_if

//--- fims_sticky.sv
// Purpose: bank of sticky status bits, cleared by the reader
// Assumes: set and clear come from the same clock domain
// Notes:   a set in the clearing cycle wins, so no event is lost
`timescale 1ns/100ps
module fims_sticky #(
    parameter int W = 1
) (
    input  wire logic     clk,
    input  wire logic     rstn,
    fims_stat_if.owner    sb
);
    logic [W-1:0] stat_q;
    logic [W-1:0] stat_d;

    // hold until cleared, set dominates clear
    assign stat_d  = (stat_q & ~sb.clr) | sb.set;
    assign sb.stat = stat_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end

    // a set bit appears next cycle even against a clear
    sticky_set_a: assert property (@(posedge clk) disable iff (!rstn)
        (sb.set != '0) |=> ((stat_q & $past(sb.set)) == $past(sb.set)))
        else $error("sticky bit lost its set");
endmodule : fims_sticky

//--- fims_fault_status.sv
// Purpose: fault mask, audio and monitor status, speaker-safe protection
// Assumes: detector pins are asynchronous; control bits share clk
// Notes:   a status register read clears the sticky flags it returned
//
// Operation
// - mask bit 1 blocks its source, 0 passes it; fault mask resets all ones
// - fault mask bits 7..0: undervoltage, lamp2/1 open/short, battery, boost
// - status flags are read-only and sticky until the clearing action
// - audio status bits 4..0 sync, clock, short, warning, error; 7:5 zero
// - sync-loss flag sets whenever clock ratio is invalid
// - watchdog flags master clock below 1.25 MHz, clear while above
// - on clock loss the amplifier stops switching and clamps outputs
// - output short sets its flag and enters speaker-safe state
// - short protection leaves only after short ends and release sequence
// - short detector is blind while powered down or speaker-safe
// - thermal warning sets its flag without any protective state
// - thermal error sets flag, enters safe state, leaves after release
// - monitor status: overflow flags in 7,6,5; 4:1 zero; bit 0 done
// - overflow flag sets when its monitor path clips
// - current monitor scale setting alone may set current overflow
// - power-down-done is 0 while clock is needed, else 1, resets to 1
// - release bit acts on 0-1-0; safe clears only with no cause left
// - thermal error reappearing during release keeps protection and sets status
`timescale 1ns/100ps
module fims_fault_status
    import fims_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic [fims_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [fims_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [fims_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic                          mclk_pin,
    input  wire logic                          ratio_invalid_pin,
    input  wire logic                          output_short_pin,
    input  wire logic                          thermal_warning_pin,
    input  wire logic                          thermal_error_pin,
    input  wire logic                          vmon_clip_pin,
    input  wire logic                          imon_clip_pin,
    input  wire logic                          vpmon_clip_pin,
    input  wire logic                          need_clock_pin,
    input  wire logic                          global_power_down,
    input  wire logic                          amplifier_power_down,
    input  wire logic                          short_release,
    input  wire logic                          thermal_release,
    input  wire logic [fims_pkg::SCALE_W-1:0]  current_monitor_scale,
    input  wire logic [fims_pkg::DATA_W-1:0]   audio_mask,
    input  wire logic [fims_pkg::DATA_W-1:0]   monitor_mask,
    input  wire logic [fims_pkg::DATA_W-1:0]   led_boost_status,
    output logic                               int_out,
    output logic                               speaker_safe,
    output logic                               amp_clamp,
    output logic                               amp_switch_en,
    output logic                               power_down_done
);
    import fims_pkg::*;

    logic [PIN_N-1:0]   sync1_q;
    logic [PIN_N-1:0]   sync2_q;
    logic [PIN_N-1:0]   pins;
    logic               mclk_s;
    logic               ratio_s;
    logic               short_s;
    logic               warn_s;
    logic               err_s;
    logic               vclip_s;
    logic               iclip_s;
    logic               pclip_s;
    logic               need_s;
    logic               mclk_prev_q;
    logic               mclk_edge;
    logic [WD_W-1:0]    wd_cnt_q;
    logic [WD_W-1:0]    wd_cnt_d;
    logic               mclk_lost_q;
    logic               mclk_lost_d;
    logic [DATA_W-1:0]  fmask_q;
    logic [DATA_W-1:0]  rdata_q;
    logic [DATA_W-1:0]  rdata_d;
    logic               int_q;
    logic               int_d;
    logic               safe_q;
    logic               safe_d;
    logic               switch_q;
    logic               switch_d;
    logic               pwr_done_q;
    logic               pwr_done_d;
    logic               short_cause_q;
    logic               short_cause_d;
    logic               therm_cause_q;
    logic               therm_cause_d;
    fims_rel_type       srel_q;
    fims_rel_type       trel_q;
    logic               short_end;
    logic               therm_end;
    logic               therm_reap_q;
    logic               short_seen;
    logic               scale_ovf;
    logic               sel_mask;
    logic               sel_audio;
    logic               sel_mon;
    logic [DATA_W-1:0]  audio_word;
    logic [DATA_W-1:0]  mon_word;
    logic               aud_pend;
    logic               mon_pend;
    logic               lb_pend;

    fims_stat_if #(.W(AUD_W)) aud_if ();
    fims_stat_if #(.W(MON_W)) mon_if ();

    // every detector pin passes two flops before any logic sees it
    assign pins = {need_clock_pin, vpmon_clip_pin, imon_clip_pin,
                   vmon_clip_pin, thermal_error_pin, thermal_warning_pin,
                   output_short_pin, ratio_invalid_pin, mclk_pin};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    assign mclk_s  = sync2_q[0];
    assign ratio_s = sync2_q[1];
    assign short_s = sync2_q[2];
    assign warn_s  = sync2_q[3];
    assign err_s   = sync2_q[4];
    assign vclip_s = sync2_q[5];
    assign iclip_s = sync2_q[6];
    assign pclip_s = sync2_q[7];
    assign need_s  = sync2_q[8];

    // clock watchdog: a period longer than the slowest legal clock is loss
    assign mclk_edge   = mclk_s & ~mclk_prev_q;
    assign wd_cnt_d    = mclk_edge ? WD_ZERO :
                         (wd_cnt_q == WD_MAX_CYC) ? wd_cnt_q :
                         wd_cnt_q + WD_ONE;
    assign mclk_lost_d = ~mclk_edge & (wd_cnt_d == WD_MAX_CYC);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mclk_prev_q <= 1'b0;
            wd_cnt_q    <= WD_ZERO;
            mclk_lost_q <= 1'b0;
        end else begin
            mclk_prev_q <= mclk_s;
            wd_cnt_q    <= wd_cnt_d;
            mclk_lost_q <= mclk_lost_d;
        end
    end

    // register decode; unmapped addresses read as zero
    assign sel_mask  = (reg_addr == FAULT_MASK_ADDR);
    assign sel_audio = (reg_addr == AUDIO_STAT_ADDR);
    assign sel_mon   = (reg_addr == MON_STAT_ADDR);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            fmask_q <= FAULT_MASK_RST;
        end else if (reg_wr && sel_mask) begin
            fmask_q <= reg_wdata;
        end
    end

    // short detector is blind while powered down, safe or releasing
    assign short_seen = short_s & ~amplifier_power_down & ~safe_q
                        & (srel_q == FIMS_REL_IDLE);

    // release sequences: armed on a 1, acted upon at the return to 0
    assign short_end = (srel_q == FIMS_REL_ARMED) & ~short_release;
    assign therm_end = (trel_q == FIMS_REL_ARMED) & ~thermal_release;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            srel_q       <= FIMS_REL_IDLE;
            trel_q       <= FIMS_REL_IDLE;
            therm_reap_q <= 1'b0;
        end else begin
            srel_q       <= short_release ? FIMS_REL_ARMED : FIMS_REL_IDLE;
            trel_q       <= thermal_release ? FIMS_REL_ARMED : FIMS_REL_IDLE;
            therm_reap_q <= thermal_release & (therm_reap_q | err_s);
        end
    end

    // a cause holds until its release ends with the condition gone
    assign short_cause_d = short_seen |
        (short_cause_q & ~(short_end & ~short_s));
    assign therm_cause_d = err_s |
        (therm_cause_q & ~(therm_end & ~therm_reap_q));
    assign safe_d        = short_cause_d | therm_cause_d;
    // clock loss stops switching at once, not waiting for a release
    assign switch_d      = ~amplifier_power_down & ~global_power_down
                           & ~mclk_lost_d & ~safe_d;
    assign pwr_done_d    = ~need_s;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            short_cause_q <= 1'b0;
            therm_cause_q <= 1'b0;
            safe_q        <= 1'b0;
            switch_q      <= 1'b0;
            pwr_done_q    <= PWR_DONE_RST;
        end else begin
            short_cause_q <= short_cause_d;
            therm_cause_q <= therm_cause_d;
            safe_q        <= safe_d;
            switch_q      <= switch_d;
            pwr_done_q    <= pwr_done_d;
        end
    end

    // sticky status sources; warning never touches the safe state
    assign aud_if.set[AUD_SYNC_BIT]  = ratio_s;
    assign aud_if.set[AUD_MCLK_BIT]  = mclk_lost_d;
    assign aud_if.set[AUD_SHORT_BIT] = short_seen;
    assign aud_if.set[AUD_WARN_BIT]  = warn_s;
    assign aud_if.set[AUD_ERR_BIT]   = err_s;
    assign aud_if.clr = {AUD_W{reg_rd & sel_audio}};

    assign scale_ovf  = (current_monitor_scale == SCALE_OVF_CODE);
    assign mon_if.set = {vclip_s, iclip_s | scale_ovf, pclip_s};
    assign mon_if.clr = {MON_W{reg_rd & sel_mon}};

    fims_sticky #(.W(AUD_W)) u_audio_stat (
        .clk  (clk),
        .rstn (rstn),
        .sb   (aud_if)
    );

    fims_sticky #(.W(MON_W)) u_mon_stat (
        .clk  (clk),
        .rstn (rstn),
        .sb   (mon_if)
    );

    // read words; reserved bits are zero
    assign audio_word = {{(DATA_W - AUD_W){1'b0}}, aud_if.stat};
    assign mon_word   = {mon_if.stat, {(MON_LSB - 1){1'b0}},
                         pwr_done_q};
    assign rdata_d    = !reg_rd   ? rdata_q    :
                        sel_mask  ? fmask_q    :
                        sel_audio ? audio_word :
                        sel_mon   ? mon_word   : DATA_ZERO;

    // interrupt: any status bit with a clear mask bit
    assign aud_pend = |(audio_word & ~audio_mask);
    assign mon_pend = |(mon_word & ~monitor_mask);
    assign lb_pend  = |(led_boost_status & ~fmask_q);
    assign int_d    = aud_pend | mon_pend | lb_pend;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_q <= DATA_ZERO;
            int_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            int_q   <= int_d;
        end
    end

    assign reg_rdata       = rdata_q;
    assign int_out         = int_q;
    assign speaker_safe    = safe_q;
    assign amp_clamp       = mclk_lost_q;
    assign amp_switch_en   = switch_q;
    assign power_down_done = pwr_done_q;

    // checks on the protective and status behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    mask_reset_a: assert property (disable iff (1'b0)
        !rstn |=> (fmask_q == FAULT_MASK_RST))
        else $error("fault mask not all ones after reset");

    unmasked_int_a: assert property (
        (|(led_boost_status & ~fmask_q)) |=> int_out)
        else $error("unmasked fault did not raise interrupt");

    status_hold_a: assert property (
        ((aud_if.stat != '0) && !(reg_rd && sel_audio)) |=>
        ((aud_if.stat & $past(aud_if.stat)) == $past(aud_if.stat)))
        else $error("audio status bit dropped without a read");

    sync_flag_a: assert property (
        ratio_s |=> aud_if.stat[AUD_SYNC_BIT])
        else $error("sync loss flag not set");

    clock_ok_a: assert property (
        mclk_edge |-> ##1 !amp_clamp ##1 !amp_clamp)
        else $error("clock loss shown right after an edge");

    clamp_stop_a: assert property (
        amp_clamp |-> !amp_switch_en)
        else $error("amplifier switching during clock loss");

    short_safe_a: assert property (
        short_seen |=> speaker_safe && aud_if.stat[AUD_SHORT_BIT])
        else $error("short did not enter safe state");

    short_blind_a: assert property (
        ((amplifier_power_down || speaker_safe)
         && !aud_if.stat[AUD_SHORT_BIT]) |=> !aud_if.stat[AUD_SHORT_BIT])
        else $error("short flagged while blind");

    safe_hold_a: assert property (
        (speaker_safe && !short_end && !therm_end && !$rose(rstn)) |=>
        speaker_safe)
        else $error("safe state left without a release");

    therm_safe_a: assert property (
        err_s |=> speaker_safe [*2])
        else $error("thermal error did not hold safe state");

    scale_ovf_a: assert property (
        scale_ovf |=> mon_if.stat[MON_IOV_BIT - MON_LSB])
        else $error("scale setting did not set overflow");

    pwr_done_a: assert property (
        need_s |=> !power_down_done)
        else $error("done shown while clock needed");

    warn_only_a: assert property (
        (!speaker_safe && !err_s && !short_seen) |=> !speaker_safe)
        else $error("safe state entered without a cause");

    release_clear_a: assert property (
        (short_end && !short_s && !therm_cause_q && !err_s) |=>
        !speaker_safe)
        else $error("safe state kept after a clean release");

    audio_reserved_a: assert property (
        (reg_rd && sel_audio) |=> ((reg_rdata >> AUD_W) == DATA_ZERO))
        else $error("reserved audio status bits not zero");

    mon_reserved_a: assert property (
        (reg_rd && sel_mon) |=>
        (reg_rdata[MON_LSB-1:MON_PDN_BIT+1] == '0))
        else $error("reserved monitor status bits not zero");
endmodule : fims_fault_status

//--- fims_host_model.sv
// Purpose: host processor model driving the control port and release bits
// Assumes: strobes go out 1 ns after a clock edge and last one cycle
// Notes:   released address and data lines show the inverted last value
`timescale 1ns/100ps
module fims_host_model (
    input  wire logic                        clk,
    output logic [fims_pkg::ADDR_W-1:0]      reg_addr,
    output logic [fims_pkg::DATA_W-1:0]      reg_wdata,
    output logic                             reg_wr,
    output logic                             reg_rd,
    output logic                             short_release,
    output logic                             thermal_release
);
    import fims_pkg::*;

    // idle levels from time zero
    initial begin
        reg_addr        = 8'h00;
        reg_wdata       = 8'h00;
        reg_wr          = 1'b0;
        reg_rd          = 1'b0;
        short_release   = 1'b0;
        thermal_release = 1'b0;
    end

    // one write, strobe held across the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    // every register is read by its own access, never in a burst
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
    endtask : rd

    // release bit walks 0 -> 1 -> 0; the 1 phase spans two edges
    task automatic release_seq(input logic thermal);
        @(posedge clk);
        #1;
        if (thermal) begin
            thermal_release = 1'b1;
        end else begin
            short_release = 1'b1;
        end
        repeat (2) @(posedge clk);
        #1;
        thermal_release = 1'b0;
        short_release   = 1'b0;
    endtask : release_seq
endmodule : fims_host_model

//--- tb_top.sv
// Purpose: self-checking bench for the fault mask and status block
// Assumes: 20 MHz core clock, master clock pin toggled at 5 MHz
// Notes:   read words are checked from a queue one edge after the strobe
`timescale 1ns/100ps
module tb_top;
    import fims_pkg::*;
    localparam int PDN = 0, SW = 1, CLAMP = 2, SAFE = 3, INT = 4;
    logic       clk = 1'b0, rstn = 1'b0, mclk_pin = 1'b0, mclk_run = 1'b1;
    logic [7:0] pins = 8'h00, audio_mask = 8'hff, monitor_mask = 8'hff;
    logic [7:0] led_boost_status = 8'h00, m;
    logic       global_power_down = 1'b0, amplifier_power_down = 1'b0;
    logic [1:0] current_monitor_scale = 2'h0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       reg_wr, reg_rd, short_release, thermal_release, rd_prev;
    logic       int_out, speaker_safe, amp_clamp, amp_switch_en;
    logic       power_down_done;
    logic [4:0] obs;
    logic [7:0] exp_q[$];
    int         error_cnt = 0, cmp_count = 0;

    assign obs = {int_out, speaker_safe, amp_clamp, amp_switch_en,
                  power_down_done};

    // core clock, and a master clock that can be stopped mid-run
    always #25 clk = ~clk;
    always #100 mclk_pin = mclk_run ? ~mclk_pin : mclk_pin;

    fims_host_model u_fims_host_model (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .short_release(short_release),
        .thermal_release(thermal_release));

    fims_fault_status u_fims_fault_status (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mclk_pin(mclk_pin),
        .ratio_invalid_pin(pins[0]), .output_short_pin(pins[1]),
        .thermal_warning_pin(pins[2]), .thermal_error_pin(pins[3]),
        .vmon_clip_pin(pins[4]), .imon_clip_pin(pins[5]),
        .vpmon_clip_pin(pins[6]), .need_clock_pin(pins[7]),
        .global_power_down(global_power_down),
        .amplifier_power_down(amplifier_power_down),
        .short_release(short_release), .thermal_release(thermal_release),
        .current_monitor_scale(current_monitor_scale),
        .audio_mask(audio_mask), .monitor_mask(monitor_mask),
        .led_boost_status(led_boost_status), .int_out(int_out),
        .speaker_safe(speaker_safe), .amp_clamp(amp_clamp),
        .amp_switch_en(amp_switch_en), .power_down_done(power_down_done));

    task automatic final_report();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [7:0] s, input logic [7:0] e,
                       input string msg);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg,
                     s, e);
        end
    endtask : chk

    // lets n edges pass, then steps off the edge before driving
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // bounded wait for one output to reach a level; a hang ends the run
    task automatic wait_sig(input int sel, input logic v, input string msg);
        int k;
        for (k = 0; k < 40; k++) begin
            if (obs[sel] === v) break;
            step(1);
        end
        chk({7'h00, obs[sel]}, {7'h00, v}, msg);
        if (k == 40) final_report();
    endtask : wait_sig

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_fims_host_model.rd(a);
    endtask : rd

    task automatic do_reset();
        rstn = 1'b0;
        step(5);
        rstn = 1'b1;
        step(4);
    endtask : do_reset

    task automatic pulse(input int i);
        pins[i] = 1'b1;
        step(4);
        pins[i] = 1'b0;
        step(5);
    endtask : pulse

    // read word is settled at the edge after the taking edge
    always @(posedge clk) begin
        if (rd_prev === 1'b1 && exp_q.size() > 0) begin
            chk(reg_rdata, exp_q.pop_front(), "read word");
        end
        rd_prev = reg_rd;
    end

    // a hang anywhere ends the run as a failure
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    initial begin
        void'($urandom(32'h53cf));
        do_reset();
        rd(FAULT_MASK_ADDR, 8'hff);
        rd(AUDIO_STAT_ADDR, 8'h00);
        rd(MON_STAT_ADDR, 8'h01);
        wait_sig(PDN, 1'b1, "pdn reset");
        m = 8'($urandom());
        u_fims_host_model.wr(FAULT_MASK_ADDR, m);
        rd(FAULT_MASK_ADDR, m);
        u_fims_host_model.wr(AUDIO_STAT_ADDR, ~m);
        rd(AUDIO_STAT_ADDR, 8'h00);
        rd(8'h20, 8'h00);
        // each mask bit gates its own source onto the interrupt
        for (int i = 0; i < 8; i++) begin
            led_boost_status = 8'h01 << i;
            u_fims_host_model.wr(FAULT_MASK_ADDR, ~(8'h01 << i));
            wait_sig(INT, 1'b1, "unmasked");
            u_fims_host_model.wr(FAULT_MASK_ADDR, 8'hff);
            wait_sig(INT, 1'b0, "masked");
        end
        led_boost_status = 8'h00;
        pulse(0);
        rd(AUDIO_STAT_ADDR, 8'h10);
        pulse(2);
        rd(AUDIO_STAT_ADDR, 8'h02);
        wait_sig(SAFE, 1'b0, "warn safe");
        rd(AUDIO_STAT_ADDR, 8'h00);
        // short while powered down must stay invisible
        amplifier_power_down = 1'b1;
        pulse(1);
        rd(AUDIO_STAT_ADDR, 8'h00);
        wait_sig(SAFE, 1'b0, "pdn short");
        amplifier_power_down = 1'b0;
        audio_mask = 8'hfb;
        step(3);
        pulse(1);
        wait_sig(SAFE, 1'b1, "short safe");
        wait_sig(SW, 1'b0, "short switch");
        wait_sig(INT, 1'b1, "short int");
        rd(AUDIO_STAT_ADDR, 8'h04);
        wait_sig(INT, 1'b0, "short int clr");
        wait_sig(SAFE, 1'b1, "safe held");
        u_fims_host_model.release_seq(1'b0);
        wait_sig(SAFE, 1'b0, "short rel");
        wait_sig(SW, 1'b1, "resume");
        // thermal error held on through the release keeps protection
        pins[3] = 1'b1;
        wait_sig(SAFE, 1'b1, "err safe");
        u_fims_host_model.release_seq(1'b1);
        step(6);
        wait_sig(SAFE, 1'b1, "err kept");
        rd(AUDIO_STAT_ADDR, 8'h01);
        pins[3] = 1'b0;
        step(5);
        rd(AUDIO_STAT_ADDR, 8'h01);
        rd(AUDIO_STAT_ADDR, 8'h00);
        u_fims_host_model.release_seq(1'b1);
        wait_sig(SAFE, 1'b0, "err rel");
        for (int i = 0; i < 3; i++) begin
            pulse(4 + i);
            rd(MON_STAT_ADDR, (8'h80 >> i) | 8'h01);
        end
        current_monitor_scale = SCALE_OVF_CODE;
        step(5);
        current_monitor_scale = 2'h0;
        step(5);
        rd(MON_STAT_ADDR, 8'h41);
        rd(MON_STAT_ADDR, 8'h01);
        monitor_mask = 8'h7f;
        pulse(4);
        wait_sig(INT, 1'b1, "mon int");
        rd(MON_STAT_ADDR, 8'h81);
        wait_sig(INT, 1'b0, "mon int clr");
        monitor_mask = 8'hff;
        pins[7] = 1'b1;
        wait_sig(PDN, 1'b0, "clock needed");
        rd(MON_STAT_ADDR, 8'h00);
        global_power_down = 1'b1;
        pins[7] = 1'b0;
        wait_sig(PDN, 1'b1, "done again");
        global_power_down = 1'b0;
        // stopped master clock clamps the outputs
        mclk_run = 1'b0;
        wait_sig(CLAMP, 1'b1, "clamp");
        wait_sig(SW, 1'b0, "clamp switch");
        rd(AUDIO_STAT_ADDR, 8'h08);
        mclk_run = 1'b1;
        wait_sig(CLAMP, 1'b0, "clamp off");
        do_reset();
        rd(FAULT_MASK_ADDR, 8'hff);
        step(3);
        final_report();
    end
endmodule : tb_top
